//--- bench/test_uff_ctrl.sv
// Self-checking testbench for the FIFO and DMA control slice.
// Assumes uff_ctrl, uff_pkg and the DMA partner model.
`timescale 1ns/1ns
module test_uff_ctrl;
  import uff_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rv;
  logic [1:0]  rs;
  logic        tx_unload, rx_load, rx_timeout, tx_burst, rx_drain;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        tx_write, rx_read, tx_n, rx_n;
  logic [4:0]  lvl [4];
  int          fail_count, total_checks;

  uff_ctrl uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_write(tx_write),
    .tx_unload(tx_unload), .rx_load(rx_load), .rx_read(rx_read),
    .rx_timeout(rx_timeout), .tx_space_ready_n(tx_n),
    .rx_data_ready_n(rx_n), .irq(irq));

  uff_dma_partner dma (.aclk(aclk), .aresetn(aresetn), .tx_burst(tx_burst),
    .rx_drain(rx_drain), .tx_space_ready_n(tx_n), .rx_data_ready_n(rx_n),
    .tx_write(tx_write), .rx_read(rx_read));

  task automatic chk(input string what, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic hang(input string what);
    fail_count++;
    $display("MISMATCH %s expected answer seen none", what);
    tally_and_finish;
  endtask

  // Bus tasks start just after an edge and leave one edge spare
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    if (n >= 100) hang("write answer");
    rs = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [3:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    if (n >= 100) hang("read answer");
    rv = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  function automatic logic [31:0] fld(input int lo, input int w);
    return (rv >> lo) & ((32'h1 << w) - 32'h1);
  endfunction

  // Strobes: 0 shifter unload, 1 receive load, 2 receive time-out
  task automatic pulse(input int which, input int cnt);
    repeat (cnt) begin
      case (which)
        0: tx_unload <= 1'b1;
        1: rx_load <= 1'b1;
        default: rx_timeout <= 1'b1;
      endcase
      @(posedge aclk);
      tx_unload <= 1'b0;
      rx_load <= 1'b0;
      rx_timeout <= 1'b0;
      repeat (3) @(posedge aclk);
    end
  endtask

  task automatic wait_pin(input logic tx, input logic level);
    int n;
    for (n = 0; n < 400; n++) begin
      @(posedge aclk);
      if ((tx ? tx_n : rx_n) === level) break;
    end
    if (n >= 400) hang("ready pin");
  endtask

  task automatic t_reset;
    chk("tx ready", 1'b0, tx_n);
    chk("rx ready", 1'b1, rx_n);
    rd(OFF_STATE);
    chk("state", 32'h1 << STATE_RX_DATA_READY_N, rv);
    chk("state resp", RESP_OKAY, rs);
  endtask

  task automatic t_mode0;
    tx_burst <= 1'b1;
    wait_pin(1'b1, 1'b1);
    tx_burst <= 1'b0;
    rd(OFF_STATE);
    chk("tx count", HOLD_DEPTH, fld(STATE_TX_LO, 5));
    pulse(0, 1);
    chk("tx ready", 1'b0, tx_n);
    pulse(1, 1);
    chk("rx ready", 1'b0, rx_n);
    rx_drain <= 1'b1;
    wait_pin(1'b0, 1'b1);
    rx_drain <= 1'b0;
    rd(OFF_STATE);
    chk("rx count", 32'h0, fld(STATE_RX_LO, 5));
  endtask

  task automatic t_setup;
    wr(OFF_SETUP, 32'h0000_00C8);
    rd(OFF_STATE);
    chk("setup ignored", 32'h0, fld(0, 4));
    wr(OFF_SETUP, 32'h0000_00F9);
    rd(OFF_STATE);
    chk("fifo on", 32'h1, fld(STATE_FIFO_EN, 1));
    chk("dma mode", 32'h1, fld(STATE_DMA_MODE, 1));
    chk("threshold", 32'h3, fld(STATE_TRIG_LO, 2));
    rd(OFF_SETUP);
    chk("setup read", 32'h0, rv);
  endtask

  // Second fill proves the flush bit did not stick
  task automatic t_block_tx;
    repeat (2) begin
      tx_burst <= 1'b1;
      wait_pin(1'b1, 1'b1);
      tx_burst <= 1'b0;
      rd(OFF_STATE);
      chk("tx full", FIFO_DEPTH, fld(STATE_TX_LO, 5));
      rd(OFF_EVENTS);
      wr(OFF_SETUP, 32'h0000_00CD);
      repeat (3) @(posedge aclk);
      chk("tx ready", 1'b0, tx_n);
      rd(OFF_EVENTS);
      chk("tx empty event", 32'h1, fld(EV_TX_EMPTY, 1));
    end
  endtask

  task automatic t_block_rx;
    for (int c = 0; c < 4; c++) begin
      wr(OFF_SETUP, {24'h0, c[1:0], 6'h09});
      rd(OFF_EVENTS);
      pulse(1, int'(lvl[c]) - 1);
      chk("rx early", 1'b1, rx_n);
      pulse(1, 1);
      chk("rx ready", 1'b0, rx_n);
      rd(OFF_EVENTS);
      chk("rx event", 32'h1, fld(EV_RX_TRIG, 1));
      pulse(1, 1);
      rd(OFF_STATE);
      chk("rx count", 32'(lvl[c]) + 1, fld(STATE_RX_LO, 5));
      wr(OFF_SETUP, {24'h0, c[1:0], 6'h0B});
      repeat (3) @(posedge aclk);
      chk("rx flushed", 1'b1, rx_n);
    end
  endtask

  task automatic t_timeout;
    wr(OFF_SETUP, 32'h0000_0049);
    pulse(1, 2);
    chk("rx below", 1'b1, rx_n);
    pulse(2, 1);
    chk("rx timeout", 1'b0, rx_n);
    rx_drain <= 1'b1;
    wait_pin(1'b0, 1'b1);
    rx_drain <= 1'b0;
    rd(OFF_STATE);
    chk("rx drained", 32'h0, fld(STATE_RX_LO, 5));
  endtask

  // FIFOs on in mode 0: pins follow one character, not the fill
  task automatic t_fifo0;
    wr(OFF_SETUP, 32'h0000_0001);
    chk("write resp", RESP_OKAY, rs);
    tx_burst <= 1'b1;
    wait_pin(1'b1, 1'b1);
    tx_burst <= 1'b0;
    rd(OFF_STATE);
    chk("tx one", 32'h1, fld(STATE_TX_LO, 5));
    chk("rx idle", 32'h1, fld(STATE_RX_DATA_READY_N, 1));
    pulse(0, 1);
    chk("tx drained", 1'b0, tx_n);
    pulse(1, 1);
    chk("rx one", 1'b0, rx_n);
    rx_drain <= 1'b1;
    wait_pin(1'b0, 1'b1);
    rx_drain <= 1'b0;
    rd(OFF_STATE);
    chk("rx none", 32'h0, fld(STATE_RX_LO, 5));
  endtask

  task automatic t_irq;
    rd(OFF_EVENTS);
    wr(OFF_MASK, 32'h4);
    rd(OFF_MASK);
    chk("mask", 32'h4, rv);
    pulse(2, 1);
    chk("irq", 1'b1, irq);
    rd(OFF_EVENTS);
    chk("events", 32'h4, rv);
    repeat (2) @(posedge aclk);
    chk("irq cleared", 1'b0, irq);
    wr(OFF_MASK, 32'h0);
    pulse(2, 1);
    chk("irq masked", 1'b0, irq);
    wr(OFF_EVENTS, 32'h0000_0007);
    chk("read-only write", RESP_SLVERR, rs);
    rd(4'h2);
    chk("unmapped data", 32'h0, rv);
    chk("unmapped resp", RESP_SLVERR, rs);
  endtask

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {tx_unload, rx_load, rx_timeout, tx_burst, rx_drain} = '0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    wstrb = 4'hF;
    lvl = '{TRIG_LVL_0, TRIG_LVL_1, TRIG_LVL_2, TRIG_LVL_3};
    fail_count = 0;
    total_checks = 0;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_mode0;
    t_setup;
    t_block_tx;
    t_block_rx;
    t_timeout;
    t_fifo0;
    t_irq;
    tally_and_finish;
  end
endmodule

//--- bench/uff_dma_partner.sv
// Partner model: a DMA controller that writes while transmit space
// is offered and reads while received data is offered.
// Assumes the pins settle two edges after each strobe it gives.
`timescale 1ns/1ns
module uff_dma_partner (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Bench commands
  input  wire logic tx_burst,
  input  wire logic rx_drain,
  // Device pins
  input  wire logic tx_space_ready_n,
  input  wire logic rx_data_ready_n,
  output logic      tx_write,
  output logic      rx_read
);
  logic [1:0] gap_reg;
  logic       want_tx;
  logic       want_rx;

  // Transmit wins when both are offered; one strobe per gap
  assign want_tx = tx_burst && !tx_space_ready_n;
  assign want_rx = rx_drain && !rx_data_ready_n && !want_tx;

  // Gap lets a pin answer before it is trusted again
  always @(posedge aclk) begin
    if (!aresetn || gap_reg != 2'h0) begin
      tx_write <= 1'b0;
      rx_read  <= 1'b0;
      gap_reg  <= aresetn ? gap_reg - 2'h1 : 2'h0;
    end else begin
      tx_write <= want_tx;
      rx_read  <= want_rx;
      gap_reg  <= (want_tx || want_rx) ? 2'h3 : 2'h0;
    end
  end
endmodule

//--- include/uff_pkg.sv
// Package for the UART FIFO and DMA control slice: register map,
// field positions, reset values and trigger levels.
// Assumes a 32-bit AXI4-Lite register bus and 16-deep FIFOs.
package uff_pkg;
  // Register byte offsets
  localparam logic [3:0] OFF_SETUP   = 4'h0;
  localparam logic [3:0] OFF_STATE   = 4'h4;
  localparam logic [3:0] OFF_EVENTS  = 4'h8;
  localparam logic [3:0] OFF_MASK    = 4'hC;
  // Field positions of fifo_setup
  localparam int SETUP_FIFO_EN  = 0;
  localparam int SETUP_RX_FLUSH = 1;
  localparam int SETUP_TX_FLUSH = 2;
  localparam int SETUP_DMA_MODE = 3;
  localparam int SETUP_TRIG_LO  = 6;
  // Field positions of the state register
  localparam int STATE_FIFO_EN  = 0;
  localparam int STATE_DMA_MODE = 1;
  localparam int STATE_TRIG_LO  = 2;
  localparam int STATE_TX_LO    = 4;
  localparam int STATE_RX_LO    = 9;
  localparam int STATE_TX_SPACE_READY_N    = 14;
  localparam int STATE_RX_DATA_READY_N    = 15;
  // Event bits, shared by status and mask
  localparam int EV_TX_EMPTY = 0;
  localparam int EV_RX_TRIG  = 1;
  localparam int EV_RX_TOUT  = 2;
  localparam int EV_COUNT    = 3;
  // Widths and depths
  localparam int           CNT_W      = 5;
  localparam logic [4:0]   FIFO_DEPTH = 5'h10;
  localparam logic [4:0]   HOLD_DEPTH = 5'h01;
  // Receive trigger levels, in characters
  localparam logic [4:0]   TRIG_LVL_0 = 5'h01;
  localparam logic [4:0]   TRIG_LVL_1 = 5'h04;
  localparam logic [4:0]   TRIG_LVL_2 = 5'h08;
  localparam logic [4:0]   TRIG_LVL_3 = 5'h0E;
  // Reset values
  localparam logic [1:0]   TRIG_RESET = 2'h0;
  localparam logic [EV_COUNT-1:0] MASK_RESET = 3'h0;
  // Bus answers
  localparam logic [1:0]   RESP_OKAY   = 2'h0;
  localparam logic [1:0]   RESP_SLVERR = 2'h2;
endpackage

//--- logic/uff_ctrl.sv
// UART FIFO enable, flush, receive threshold and DMA signalling control.
// Assumes FIFO storage, shifters and time-out timer live outside;
// their strobes arrive from logic on aclk.
// Summary of operation
// - Mode 0: transmit-ready low when transmit FIFO or holding register empty.
// - Mode 0: transmit-ready returns high once a character is written.
// - Mode 0: receive-ready low while at least one character waits.
// - Mode 0: receive-ready returns high only when no characters remain.
// - Mode 1: transmit interrupt event when transmit FIFO becomes empty.
// - Mode 1: transmit-ready low while space remains, high only when full.
// - Mode 1: receive event at trigger level; FIFO still fills until full.
// - Mode 1: receive-ready low at trigger level or on receive time-out.
// - Mode 1: receive-ready stays low until receive FIFO is empty.
// - Setup bits 7:6 select receive threshold; event when count equals it.
// - Setup bits 5:4 unused and zero.
// - Setup bit 3 selects DMA mode 0 or 1.
// - Setup bit 2 flushes the transmit FIFO, shift register untouched.
// - Transmit flush bit clears itself after the flush.
// - Threshold codes 0..3 mean 1, 4, 8, 14 characters.
// - Setup bit 0 enables FIFOs; other bits ignored unless it is one.
// - Setup bit 1 flushes the receive FIFO, then clears itself.
`timescale 1ns/1ns
module uff_ctrl
  import uff_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Strobes from the rest of the channel
  input  wire logic        tx_write,
  input  wire logic        tx_unload,
  input  wire logic        rx_load,
  input  wire logic        rx_read,
  input  wire logic        rx_timeout,
  // DMA handshake pins and interrupt
  output logic             tx_space_ready_n,
  output logic             rx_data_ready_n,
  output logic             irq
);
  // Bus slave state
  logic        aw_got_reg;
  logic        w_got_reg;
  logic [3:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic        w_lane0_reg;
  logic        do_write;
  logic        setup_wr;
  logic        rd_take;
  logic        ev_clear;
  logic [31:0] rdata_next;
  logic        rd_hit;
  // Control fields
  logic        fifo_en_reg;
  logic        dma_mode_reg;
  logic [1:0]  rx_fill_threshold_reg;
  logic        tx_queue_flush_reg;
  logic        rx_queue_flush_reg;
  logic [EV_COUNT-1:0] mask_reg;
  // Counters and derived state
  logic [4:0]  tx_cnt;
  logic [4:0]  rx_cnt;
  logic [4:0]  tx_prev_reg;
  logic [4:0]  rx_prev_reg;
  logic [4:0]  limit;
  logic [4:0]  level;
  logic        block_mode;
  logic        rx_armed_reg;
  logic        rx_armed_next;
  logic [EV_COUNT-1:0] ev_set;
  logic [EV_COUNT-1:0] ev_flags;

  assign do_write   = aw_got_reg && w_got_reg && !s_axi_bvalid;
  assign setup_wr   = do_write && (aw_addr_reg == OFF_SETUP) && w_lane0_reg;
  assign rd_take    = s_axi_arvalid && s_axi_arready;
  assign ev_clear   = rd_take && (s_axi_araddr == OFF_EVENTS);
  assign limit      = fifo_en_reg ? FIFO_DEPTH : HOLD_DEPTH;
  assign block_mode = fifo_en_reg && dma_mode_reg;

  // Write address and data are taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg    <= 1'b0;
      aw_addr_reg   <= 4'h0;
      s_axi_awready <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg    <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (do_write) begin
        aw_got_reg <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_reg    <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_lane0_reg  <= 1'b0;
      s_axi_wready <= 1'b1;
    end else begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg    <= 1'b1;
        w_data_reg   <= s_axi_wdata;
        w_lane0_reg  <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        w_got_reg <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Response follows both halves; unmapped and read-only offsets error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr_reg == OFF_SETUP ||
                       aw_addr_reg == OFF_MASK) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Setup fields other than the enable bit stay put unless the enable bit comes with the write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fifo_en_reg           <= 1'b0;
      dma_mode_reg          <= 1'b0;
      rx_fill_threshold_reg <= TRIG_RESET;
      tx_queue_flush_reg    <= 1'b0;
      rx_queue_flush_reg    <= 1'b0;
    end else begin
      tx_queue_flush_reg <= 1'b0;
      rx_queue_flush_reg <= 1'b0;
      if (setup_wr) begin
        fifo_en_reg <= w_data_reg[SETUP_FIFO_EN];
        if (w_data_reg[SETUP_FIFO_EN]) begin
          dma_mode_reg          <= w_data_reg[SETUP_DMA_MODE];
          rx_fill_threshold_reg <=
            w_data_reg[SETUP_TRIG_LO +: 2];
          tx_queue_flush_reg    <= w_data_reg[SETUP_TX_FLUSH];
          rx_queue_flush_reg    <= w_data_reg[SETUP_RX_FLUSH];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_reg <= MASK_RESET;
    end else if (do_write && aw_addr_reg == OFF_MASK && w_lane0_reg) begin
      mask_reg <= w_data_reg[EV_COUNT-1:0];
    end
  end

  // Threshold decode
  always_comb begin
    case (rx_fill_threshold_reg)
      2'h0:    level = TRIG_LVL_0;
      2'h1:    level = TRIG_LVL_1;
      2'h2:    level = TRIG_LVL_2;
      2'h3:    level = TRIG_LVL_3;
      default: level = TRIG_LVL_0;
    endcase
  end

  // Read data; setup is write-only and reads zero, as do bits 5:4
  always_comb begin
    rdata_next = 32'h0000_0000;
    rd_hit     = 1'b1;
    case (s_axi_araddr)
      OFF_SETUP: rdata_next = 32'h0000_0000;
      OFF_STATE: begin
        rdata_next[STATE_FIFO_EN]       = fifo_en_reg;
        rdata_next[STATE_DMA_MODE]      = dma_mode_reg;
        rdata_next[STATE_TRIG_LO +: 2]  = rx_fill_threshold_reg;
        rdata_next[STATE_TX_LO +: 5]    = tx_cnt;
        rdata_next[STATE_RX_LO +: 5]    = rx_cnt;
        rdata_next[STATE_TX_SPACE_READY_N]         = tx_space_ready_n;
        rdata_next[STATE_RX_DATA_READY_N]         = rx_data_ready_n;
      end
      OFF_EVENTS: rdata_next[EV_COUNT-1:0] = ev_flags;
      OFF_MASK:   rdata_next[EV_COUNT-1:0] = mask_reg;
      default:    rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rdata_next;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // Flushes reset only the counters; shifters are outside this slice
  uff_occ_counter #(.W(CNT_W)) u_tx_cnt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .flush   (tx_queue_flush_reg),
    .push    (tx_write),
    .pop     (tx_unload),
    .limit   (limit),
    .count   (tx_cnt)
  );

  uff_occ_counter #(.W(CNT_W)) u_rx_cnt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .flush   (rx_queue_flush_reg),
    .push    (rx_load),
    .pop     (rx_read),
    .limit   (limit),
    .count   (rx_cnt)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_prev_reg <= 5'h00;
      rx_prev_reg <= 5'h00;
    end else begin
      tx_prev_reg <= tx_cnt;
      rx_prev_reg <= rx_cnt;
    end
  end

  // Edge-detected so a FIFO parked at a level raises one event only
  always_comb begin
    ev_set              = '0;
    ev_set[EV_TX_EMPTY] = (tx_prev_reg != 5'h00) && (tx_cnt == 5'h00);
    ev_set[EV_RX_TRIG]  = fifo_en_reg && (rx_cnt == level) &&
                          (rx_prev_reg != level);
    ev_set[EV_RX_TOUT]  = rx_timeout;
  end

  uff_event_flags #(.N(EV_COUNT)) u_events (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (ev_set),
    .clear   (ev_clear),
    .mask    (mask_reg),
    .flags   (ev_flags),
    .irq     (irq)
  );

  // Block mode receive latch: armed at threshold or time-out
  always_comb begin
    if (rx_cnt >= level || rx_timeout) begin
      rx_armed_next = 1'b1;
    end else if (rx_cnt == 5'h00) begin
      rx_armed_next = 1'b0;
    end else begin
      rx_armed_next = rx_armed_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_armed_reg <= 1'b0;
    end else begin
      rx_armed_reg <= rx_armed_next;
    end
  end

  // Pins lag the counters by one cycle to come straight from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_space_ready_n <= 1'b0;
      rx_data_ready_n  <= 1'b1;
    end else if (block_mode) begin
      tx_space_ready_n <= (tx_cnt >= FIFO_DEPTH);
      rx_data_ready_n  <= !rx_armed_next;
    end else begin
      tx_space_ready_n <= (tx_cnt != 5'h00);
      rx_data_ready_n  <= (rx_cnt == 5'h00);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_tx_rdy_empty: assert property (
    (!block_mode && tx_cnt == 5'h00) |=> !tx_space_ready_n)
    else $error("transmit-ready not low with empty queue in mode 0");
  a_tx_rdy_loaded: assert property (
    (!block_mode && $rose(tx_cnt != 5'h00)) |=> tx_space_ready_n)
    else $error("transmit-ready not high after a write in mode 0");
  a_rx_rdy_wait: assert property (
    (!block_mode && rx_cnt != 5'h00) |=> !rx_data_ready_n)
    else $error("receive-ready not low with data in mode 0");
  a_rx_rdy_drain: assert property (
    (!block_mode && rx_cnt == 5'h00) |=> rx_data_ready_n)
    else $error("receive-ready not high when drained in mode 0");
  a_tx_empty_event: assert property (
    (tx_cnt != 5'h00 ##1 tx_cnt == 5'h00) |=> ev_flags[EV_TX_EMPTY])
    else $error("transmit empty event not flagged");
  a_tx_full_pin: assert property (
    block_mode |=> (tx_space_ready_n == $past(tx_cnt == FIFO_DEPTH)))
    else $error("transmit-ready wrong in block mode");
  a_rx_trig_event: assert property (
    (fifo_en_reg && rx_prev_reg == 5'h03 && rx_cnt == 5'h04 &&
     rx_fill_threshold_reg == 2'h1) |=> ev_flags[EV_RX_TRIG])
    else $error("receive threshold event not flagged at four");
  a_rx_blk_low: assert property (
    (block_mode && (rx_cnt >= level || rx_timeout)) |=> !rx_data_ready_n)
    else $error("receive-ready not low at threshold in block mode");
  a_rx_blk_hold: assert property (
    (block_mode ##1 block_mode && !rx_data_ready_n && rx_cnt != 5'h00
     ##1 block_mode) |=> !rx_data_ready_n || $past(rx_cnt == 5'h00))
    else $error("receive-ready released before drain in block mode");
  a_tx_flush_pulse: assert property (
    (setup_wr && w_data_reg[SETUP_FIFO_EN] && w_data_reg[SETUP_TX_FLUSH])
      |=> tx_queue_flush_reg ##1 (!tx_queue_flush_reg && tx_cnt == 5'h00))
    else $error("transmit flush did not empty and self-clear");
  a_setup_gated: assert property (
    (setup_wr && !w_data_reg[SETUP_FIFO_EN])
      |=> !fifo_en_reg && $stable(dma_mode_reg) && !rx_queue_flush_reg)
    else $error("setup bits taken without the enable bit");
endmodule

//--- logic/uff_event_flags.sv
// Sticky event flags with mask and one level interrupt.
// Assumes clear is a one-cycle pulse from a status read.
`timescale 1ns/1ns
module uff_event_flags
  import uff_pkg::*;
#(
  parameter int N = EV_COUNT
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Events and software side
  input  wire logic [N-1:0] set,
  input  wire logic         clear,
  input  wire logic [N-1:0] mask,
  // Outputs
  output logic      [N-1:0] flags,
  output logic              irq
);
  logic [N-1:0] flags_next;

  // Set wins over a read clear in the same cycle, so no event is lost
  always_comb begin
    flags_next = (clear ? '0 : flags) | set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= '0;
      irq   <= 1'b0;
    end else begin
      flags <= flags_next;
      irq   <= |(flags_next & mask);
    end
  end
endmodule

//--- logic/uff_occ_counter.sv
// Occupancy counter for one FIFO: counts characters held.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/1ns
module uff_occ_counter
  import uff_pkg::*;
#(
  parameter int W = CNT_W
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Control
  input  wire logic         flush,
  input  wire logic         push,
  input  wire logic         pop,
  input  wire logic [W-1:0] limit,
  // State
  output logic      [W-1:0] count
);
  logic full;
  logic empty;

  assign full  = (count >= limit);
  assign empty = (count == '0);

  // Pushes past the limit are dropped; no overrun flag is kept
  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      count <= '0;
    end else if ((push && !full) && !(pop && !empty)) begin
      count <= count + W'(1);
    end else if (!(push && !full) && (pop && !empty)) begin
      count <= count - W'(1);
    end
  end
endmodule
